// File: tcw_pkg.sv
// package for the timer compare and waveform unit
// assumes a single clk_sys domain and an AHB-Lite master outside
package tcw_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_IRQEN = 8'h10;
  localparam logic [7:0] OFS_PORT = 8'h14;

  // field positions
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 2;
  localparam int CTRL_CS_LSB = 4;
  localparam int CTRL_FOC_BIT = 7;
  localparam int FLG_CM_BIT = 0;
  localparam int FLG_OV_BIT = 1;
  localparam int PORT_DATA_BIT = 0;
  localparam int PORT_DIR_BIT = 1;

  // reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] RST_COM = 2'h0;
  localparam logic [2:0] RST_CS = 3'h0;

  // waveform_mode_select encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PC = 2'h1;
  localparam logic [1:0] MODE_CTC = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  // compare_output_action encodings
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // prescaler terminal counts (divide-by minus one) for clock_source_select 1..7
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_LAST_1 = 10'h000;
  localparam logic [PRE_W-1:0] PRE_LAST_8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_LAST_32 = 10'h01f;
  localparam logic [PRE_W-1:0] PRE_LAST_64 = 10'h03f;
  localparam logic [PRE_W-1:0] PRE_LAST_128 = 10'h07f;
  localparam logic [PRE_W-1:0] PRE_LAST_256 = 10'h0ff;
  localparam logic [PRE_W-1:0] PRE_LAST_1024 = 10'h3ff;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } tcw_ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } tcw_ahb_rsp_type;

  typedef struct packed {
    logic out;
    logic oe_b;
  } tcw_pin_type;

endpackage

// File: tcw_prescaler.sv
// timer clock enable generator: one-cycle tick per timer clock
// assumes clock_source_select is synchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module tcw_prescaler #(
  parameter int W = tcw_pkg::PRE_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] clock_source_select,
  output logic tick
);
  import tcw_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tcw_pre_state_type;

  tcw_pre_state_type st;
  tcw_pre_state_type next_st;

  function automatic logic [W-1:0] last_of(input logic [2:0] cs);
    case (cs)
      3'h1: last_of = W'(PRE_LAST_1);
      3'h2: last_of = W'(PRE_LAST_8);
      3'h3: last_of = W'(PRE_LAST_32);
      3'h4: last_of = W'(PRE_LAST_64);
      3'h5: last_of = W'(PRE_LAST_128);
      3'h6: last_of = W'(PRE_LAST_256);
      default: last_of = W'(PRE_LAST_1024);
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clock_source_select == 3'h0) begin
      // stopped timer: no ticks [RL24]
      next_st.cnt = '0;
    end else if (st.cnt >= last_of(clock_source_select)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  AST_STOPPED_NO_TICK: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL24]
    $past(clock_source_select) == 3'h0 |-> !tick)
    else $error("timer tick while clock source stopped");

endmodule
`default_nettype wire

// File: tcw_cmp_buffer.sv
// compare value holding: buffer register and active register
// assumes wr and update are one-cycle pulses from the core
`timescale 1ns/1ns
`default_nettype none
module tcw_cmp_buffer (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic buf_en,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic update,
  output logic [7:0] active,
  output logic [7:0] rd
);
  import tcw_pkg::*;

  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] act;
  } tcw_buf_state_type;

  tcw_buf_state_type st;
  tcw_buf_state_type next_st;

  always_comb begin
    next_st = st;
    if (wr) begin
      next_st.hold = wdata;
    end
    if (!buf_en) begin
      // unbuffered modes: processor reaches the active register [RL5] [RL7]
      if (wr) begin
        next_st.act = wdata;
      end
    end else if (update) begin
      // buffered: transfer only at top or bottom [RL6]
      next_st.act = st.hold;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st.hold <= RST_COMPARE;
      st.act <= RST_COMPARE;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.act;
  assign rd = buf_en ? st.hold : st.act; // [RL7]

  AST_BUF_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6]
    buf_en && !update |=> $stable(active))
    else $error("active compare changed outside top or bottom");

  AST_DIRECT_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL7]
    !buf_en && wr |=> active == $past(wdata))
    else $error("unbuffered compare write not applied");

endmodule
`default_nettype wire

// File: tcw_timer_compare.sv
// 8-bit timer/counter with output compare and waveform output, AHB-Lite slave
// assumes one clk_sys domain; port pin wire resolved outside from oe_b
// How it works
// [RL1] counter and compare value compared every cycle by an 8-bit equality test
// [RL2] a match sets the compare flag at the following timer clock tick
// [RL3] a set compare flag with its enable at one raises the compare interrupt
// [RL4] flag clears on interrupt acknowledge or by writing one; zero does nothing
// [RL5] compare value double buffered in PWM modes, direct in normal and CLEAR_ON_MATCH_MODE
// [RL6] buffered value moves to active register only at top or bottom
// [RL7] processor accesses buffer when buffered, active register otherwise
// [RL8] force strobe in non-PWM modes acts like a match without flag or clear
// [RL9] a counter write blocks any match at the next timer tick, even when stopped
// [RL10] software must not write counter equal to compare, nor bottom downcounting
// [RL11] waveform output keeps its state across mode changes
// [RL12] output action bits unbuffered, used at the first match after writing
// [RL13] nonzero action bits put waveform on pin; direction bit still rules
// [RL14] waveform state can be set up before the pin drives
// [RL15] software should set waveform state, then direction, using force strobe
// [RL16] action field zero means no waveform change on a match
// [RL17] non-PWM: set, clear or toggle; PWM: inverted or non-inverted output
// [RL18] counting depends only on the mode field, never on action bits
// [RL19] normal mode counts up, wraps 0xff to 0x00, never clears on match
// [RL20] overflow flag set as the counter becomes zero; counting never clears it
// [RL21] CLEAR_ON_MATCH_MODE mode clears the counter to zero on a compare match
// [RL22] fast PWM counts bottom to max; clear on match, set at bottom
// [RL23] phase correct counts up then down; clear on up match, set on down
// [RL24] counter write beats count and clear; clock select zero stops the timer
// [RL25] non-PWM action codes: one toggle, two clear, three set
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module tcw_timer_compare (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire tcw_pkg::tcw_ahb_req_type ahb_req,
  output tcw_pkg::tcw_ahb_rsp_type ahb_rsp,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic compare_irq,
  output logic overflow_irq,
  output tcw_pkg::tcw_pin_type oc_pin
);
  import tcw_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic down;
    logic cm_flag;
    logic ov_flag;
    logic block;
    logic oc;
    logic [1:0] mode;
    logic [1:0] com;
    logic [2:0] cs;
    logic cm_ie;
    logic ov_ie;
    logic port_data;
    logic port_dir;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
    logic irq_cm;
    logic irq_ov;
    logic pin_out;
    logic pin_oe_b;
  } tcw_core_state_type;

  tcw_core_state_type st;
  tcw_core_state_type next_st;

  logic tmr_tick;
  logic cmp_match;
  logic [7:0] cmp_active;
  logic [7:0] cmp_rd;
  logic buf_en;
  logic buf_update;
  logic wr_cmp;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_flags;
  logic force_hit;
  logic hit;
  logic ov_set;
  logic addr_phase;
  logic [31:0] wdat;

  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == MODE_PC) || (m == MODE_FAST);
  endfunction

  // non-PWM action on the waveform output
  function automatic logic act_nonpwm(input logic [1:0] c, input logic cur);
    case (c)
      COM_TOGGLE: act_nonpwm = !cur;
      COM_CLEAR: act_nonpwm = 1'b0;
      COM_SET: act_nonpwm = 1'b1;
      default: act_nonpwm = cur;
    endcase
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input tcw_core_state_type s,
                                           input logic [7:0] cmp);
    reg_read = 32'h0000_0000;
    case (a)
      OFS_CTRL: begin
        reg_read[CTRL_WGM_LSB +: 2] = s.mode;
        reg_read[CTRL_COM_LSB +: 2] = s.com;
        reg_read[CTRL_CS_LSB +: 3] = s.cs;
      end
      OFS_COUNT: reg_read[7:0] = s.cnt;
      OFS_COMPARE: reg_read[7:0] = cmp;
      OFS_FLAGS: begin
        reg_read[FLG_CM_BIT] = s.cm_flag;
        reg_read[FLG_OV_BIT] = s.ov_flag;
      end
      OFS_IRQEN: begin
        reg_read[FLG_CM_BIT] = s.cm_ie;
        reg_read[FLG_OV_BIT] = s.ov_ie;
      end
      OFS_PORT: begin
        reg_read[PORT_DATA_BIT] = s.port_data;
        reg_read[PORT_DIR_BIT] = s.port_dir;
      end
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  tcw_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clock_source_select(st.cs),
    .tick(tmr_tick)
  );

  tcw_cmp_buffer u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .buf_en(buf_en),
    .wr(wr_cmp),
    .wdata(wdat[7:0]),
    .update(buf_update),
    .active(cmp_active),
    .rd(cmp_rd)
  );

  assign cmp_match = (st.cnt == cmp_active); // [RL1]
  assign buf_en = is_pwm(st.mode); // [RL5]
  // fast PWM reloads at bottom, phase correct at top [RL6]
  assign buf_update = tmr_tick && !wr_cnt &&
                      (((st.mode == MODE_FAST) && (st.cnt == CNT_MAX)) ||
                       ((st.mode == MODE_PC) && !st.down && (st.cnt == CNT_MAX - 8'h01)));
  assign wdat = ahb_req.hwdata;
  assign wr_ctrl = st.dp_wr && (st.dp_addr == OFS_CTRL);
  assign wr_cnt = st.dp_wr && (st.dp_addr == OFS_COUNT);
  assign wr_cmp = st.dp_wr && (st.dp_addr == OFS_COMPARE);
  assign wr_flags = st.dp_wr && (st.dp_addr == OFS_FLAGS);
  assign addr_phase = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  // blocked for one timer tick after a counter write [RL9]
  assign hit = tmr_tick && cmp_match && !st.block;

  always_comb begin
    next_st = st;
    force_hit = 1'b0;
    ov_set = 1'b0;

    if (wr_ctrl) begin
      next_st.mode = wdat[CTRL_WGM_LSB +: 2];
      next_st.com = wdat[CTRL_COM_LSB +: 2]; // takes effect at once [RL12]
      next_st.cs = wdat[CTRL_CS_LSB +: 3];
      force_hit = wdat[CTRL_FOC_BIT] && !is_pwm(next_st.mode); // [RL8]
    end
    if (st.dp_wr && (st.dp_addr == OFS_IRQEN)) begin
      next_st.cm_ie = wdat[FLG_CM_BIT];
      next_st.ov_ie = wdat[FLG_OV_BIT];
    end
    if (st.dp_wr && (st.dp_addr == OFS_PORT)) begin
      next_st.port_data = wdat[PORT_DATA_BIT];
      next_st.port_dir = wdat[PORT_DIR_BIT];
    end

    // counting follows the mode field alone [RL18]
    if (tmr_tick) begin
      case (st.mode)
        MODE_NORMAL: begin
          next_st.cnt = st.cnt + 8'h01; // [RL19]
          ov_set = (st.cnt == CNT_MAX); // [RL20]
        end
        MODE_CTC: begin
          next_st.cnt = hit ? CNT_BOTTOM : st.cnt + 8'h01; // [RL21]
          ov_set = !hit && (st.cnt == CNT_MAX);
        end
        MODE_FAST: begin
          next_st.cnt = st.cnt + 8'h01; // [RL22]
          ov_set = (st.cnt == CNT_MAX);
        end
        MODE_PC: begin
          // dual slope, one tick at max and at bottom [RL23]
          if (!st.down) begin
            if (st.cnt == CNT_MAX) begin
              next_st.cnt = st.cnt - 8'h01;
              next_st.down = 1'b1;
            end else begin
              next_st.cnt = st.cnt + 8'h01;
            end
          end else begin
            if (st.cnt == CNT_BOTTOM) begin
              next_st.cnt = st.cnt + 8'h01;
              next_st.down = 1'b0;
            end else begin
              next_st.cnt = st.cnt - 8'h01;
            end
          end
          ov_set = st.down && (st.cnt == CNT_BOTTOM + 8'h01);
        end
        default: next_st.cnt = st.cnt;
      endcase
    end
    if (!is_pwm(st.mode)) begin
      next_st.down = 1'b0;
    end

    // processor write overrides count and clear [RL24]
    if (wr_cnt) begin
      next_st.cnt = wdat[7:0];
      next_st.block = 1'b1; // [RL9]
      ov_set = 1'b0;
    end else if (tmr_tick) begin
      next_st.block = 1'b0;
    end

    // flags: clears first, hardware set wins [RL4]
    if (wr_flags && wdat[FLG_CM_BIT]) begin
      next_st.cm_flag = 1'b0;
    end
    if (wr_flags && wdat[FLG_OV_BIT]) begin
      next_st.ov_flag = 1'b0;
    end
    if (compare_irq_ack) begin
      next_st.cm_flag = 1'b0;
    end
    if (overflow_irq_ack) begin
      next_st.ov_flag = 1'b0;
    end
    if (hit) begin
      next_st.cm_flag = 1'b1; // [RL2]
    end
    if (ov_set) begin
      next_st.ov_flag = 1'b1; // [RL20]
    end

    // waveform output; mode changes leave it alone [RL11] [RL16]
    case (st.mode)
      MODE_NORMAL, MODE_CTC: begin
        if (hit || force_hit) begin
          next_st.oc = act_nonpwm(next_st.com, st.oc); // [RL17] [RL25]
        end
      end
      MODE_FAST: begin
        if (hit) begin
          next_st.oc = act_nonpwm(next_st.com, st.oc); // [RL22]
        end
        // bottom wins, so compare at max gives a steady level
        if (tmr_tick && !wr_cnt && (st.cnt == CNT_MAX)) begin
          if (next_st.com == COM_CLEAR) begin
            next_st.oc = 1'b1;
          end else if (next_st.com == COM_SET) begin
            next_st.oc = 1'b0;
          end
        end
      end
      MODE_PC: begin
        if (hit && (next_st.com == COM_CLEAR)) begin
          next_st.oc = st.down; // [RL23]
        end else if (hit && (next_st.com == COM_SET)) begin
          next_st.oc = !st.down; // [RL17]
        end
      end
      default: next_st.oc = st.oc;
    endcase

    next_st.irq_cm = next_st.cm_flag && next_st.cm_ie; // [RL3]
    next_st.irq_ov = next_st.ov_flag && next_st.ov_ie;
    // override pin data only; direction stays with the port [RL13] [RL14]
    next_st.pin_out = (next_st.com != COM_NONE) ? next_st.oc : next_st.port_data;
    next_st.pin_oe_b = !next_st.port_dir;

    // bus: zero wait states; read data taken from the updated state
    next_st.ready = 1'b1;
    next_st.dp_wr = addr_phase && ahb_req.hwrite;
    next_st.dp_addr = ahb_req.haddr[7:0];
    if (addr_phase && !ahb_req.hwrite) begin
      next_st.rdata = reg_read(ahb_req.haddr[7:0], next_st,
                               wr_cmp ? wdat[7:0] : cmp_rd); // [RL7]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.cnt <= RST_COUNT;
      st.mode <= RST_MODE;
      st.com <= RST_COM;
      st.cs <= RST_CS;
      st.ready <= 1'b1;
      st.pin_oe_b <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign ahb_rsp.hrdata = st.rdata;
  assign ahb_rsp.hreadyout = st.ready;
  assign ahb_rsp.hresp = 1'b0;
  assign compare_irq = st.irq_cm;
  assign overflow_irq = st.irq_ov;
  assign oc_pin.out = st.pin_out;
  assign oc_pin.oe_b = st.pin_oe_b;

  default clocking dflt_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  AST_MATCH_SETS_FLAG: assert property (hit |=> st.cm_flag) // [RL2]
    else $error("compare match did not set flag");

  AST_FLAG_NEEDS_MATCH: assert property ($rose(st.cm_flag) |-> $past(hit)) // [RL2]
    else $error("compare flag set without a timed match");

  AST_IRQ_RAISE: assert property (st.cm_ie && !st.cm_flag ##1 st.cm_flag // [RL3]
    |-> compare_irq == st.cm_ie)
    else $error("compare interrupt not raised");

  AST_WRITE_BLOCKS: assert property (st.block && tmr_tick // [RL9]
    && cmp_match |=> !$rose(st.cm_flag))
    else $error("match after counter write not blocked");

  AST_FORCE_NO_FLAG: assert property (force_hit && !hit && !st.cm_flag |=> !st.cm_flag) // [RL8]
    else $error("force strobe set the compare flag");

  AST_NORMAL_WRAP: assert property (st.mode == MODE_NORMAL && tmr_tick && !wr_cnt // [RL19]
    && st.cnt == CNT_MAX |=> st.cnt == CNT_BOTTOM && st.ov_flag)
    else $error("normal mode wrap or overflow wrong");

  AST_CTC_CLEAR: assert property (st.mode == MODE_CTC && hit && !wr_cnt // [RL21]
    |=> st.cnt == CNT_BOTTOM)
    else $error("CLEAR_ON_MATCH_MODE counter not cleared on match");

  AST_STOPPED: assert property ($past(st.cs) == 3'h0 && !wr_cnt |=> $stable(st.cnt)) // [RL24]
    else $error("counter moved while stopped");

  AST_PIN_OVERRIDE: assert property (st.com != COM_NONE |-> oc_pin.out == st.oc) // [RL13]
    else $error("pin not driven by waveform output");

  AST_MODE_KEEPS_OC: assert property (wr_ctrl && !hit && !force_hit // [RL11]
    && next_st.mode != st.mode |=> $stable(st.oc))
    else $error("waveform output changed on mode switch");

endmodule
`default_nettype wire

// File: tcw_pin_model.sv
// port pin model: resolves the pad level from the unit's pin drive
// assumes a weak pull-up on the pad whenever the unit does not drive it
`timescale 1ns/1ns
`default_nettype none
module tcw_pin_model (
  input wire tcw_pkg::tcw_pin_type oc_pin,
  output logic pin_level
);
  import tcw_pkg::*;
  // direction bit decides who drives; released pad floats high
  assign pin_level = oc_pin.oe_b ? 1'b1 : oc_pin.out;
endmodule
`default_nettype wire

// File: tcw_tb.sv
// self-checking bench for the timer compare and waveform unit
// assumes the unit is the only AHB-Lite slave and the pin model sits on its pad
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import tcw_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  tcw_ahb_req_type drv = '0;
  tcw_ahb_req_type bus_req;
  tcw_ahb_rsp_type bus_rsp;
  logic compare_irq_ack = 1'b0;
  logic overflow_irq_ack = 1'b0;
  logic compare_irq;
  logic overflow_irq;
  tcw_pin_type oc_pin;
  logic pin_level;
  logic [31:0] rd;
  logic m_wave;
  logic [7:0] fc [6] = '{8'h8c, 8'h88, 8'h84, 8'h84, 8'h80, 8'h04};
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int m_n;
  int t0;
  int t1;

  always #20 clk_sys = ~clk_sys;

  always_comb begin
    bus_req = drv;
    bus_req.hready = bus_rsp.hreadyout;
  end

  tcw_timer_compare dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ahb_req(bus_req),
    .ahb_rsp(bus_rsp),
    .compare_irq_ack(compare_irq_ack),
    .overflow_irq_ack(overflow_irq_ack),
    .compare_irq(compare_irq),
    .overflow_irq(overflow_irq),
    .oc_pin(oc_pin)
  );

  tcw_pin_model pin_u (
    .oc_pin(oc_pin),
    .pin_level(pin_level)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one single word transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    drv.hsel <= 1'b1;
    drv.haddr <= {24'h0, a};
    drv.htrans <= 2'h2;
    drv.hwrite <= w;
    drv.hsize <= 3'h2;
    do @(posedge clk_sys); while (bus_req.hready !== 1'b1);
    drv.htrans <= 2'h0;
    drv.hwdata <= w ? d : 32'h0;
    do @(posedge clk_sys); while (bus_req.hready !== 1'b1);
    rd = bus_rsp.hrdata;
  endtask

  task automatic wait_cmp;
    do tick(1); while (compare_irq !== 1'b1);
    t1 = cyc;
  endtask

  task automatic wait_pin(input logic v);
    do tick(1); while (pin_level !== v);
    t0 = cyc;
  endtask

  task automatic ack_cmp;
    @(posedge clk_sys);
    compare_irq_ack <= 1'b1;
    @(posedge clk_sys);
    compare_irq_ack <= 1'b0;
  endtask

  // match spacing in ticks, optionally tracking a toggling output
  task automatic period(input int exp, input int reps, input logic tog);
    repeat (reps) begin
      t0 = t1;
      ack_cmp;
      wait_cmp;
      `CHK("match_period", exp, t1 - t0)
      if (tog) begin
        m_wave = ~m_wave;
        `CHK("toggle_pin", m_wave, pin_level)
      end
    end
  endtask

  initial begin
    void'($urandom(28787));
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(8'(i * 4), 1'b0, 32'h0);
      `CHK("reset_rd", 32'h0, rd)
      `CHK("hresp", 1'b0, bus_rsp.hresp)
    end
    bus(OFS_PORT, 1'b1, 32'h1);
    bus(OFS_CTRL, 1'b1, 32'h88);
    tick(2);
    `CHK("pin_released", 1'b1, pin_level)
    bus(OFS_PORT, 1'b1, 32'h3); // state prepared before direction
    tick(2);
    `CHK("pin_wave", 1'b0, pin_level)
    m_wave = 1'b0;
    foreach (fc[i]) begin
      bus(OFS_CTRL, 1'b1, {24'h0, fc[i]});
      if (fc[i][7]) begin
        case (fc[i][3:2])
          2'h1: m_wave = ~m_wave;
          2'h2: m_wave = 1'b0;
          2'h3: m_wave = 1'b1;
          default: ;
        endcase
      end
      tick(2);
      `CHK("pin_force", (fc[i][3:2] != 2'h0) ? m_wave : 1'b1, pin_level)
    end
    bus(OFS_FLAGS, 1'b0, 32'h0);
    `CHK("force_no_flag", 32'h0, rd)
    m_n = 4 + int'($urandom % 17);
    bus(OFS_COMPARE, 1'b1, 32'(m_n));
    bus(OFS_COMPARE, 1'b0, 32'h0);
    `CHK("cmp_direct", 32'(m_n), rd)
    bus(OFS_IRQEN, 1'b1, 32'h1);
    bus(OFS_CTRL, 1'b1, 32'h16);
    wait_cmp;
    m_wave = ~m_wave;
    period(m_n + 1, 3, 1'b1);
    wait_cmp;
    bus(OFS_CTRL, 1'b1, 32'h06);
    bus(OFS_FLAGS, 1'b1, 32'h0);
    bus(OFS_FLAGS, 1'b0, 32'h0);
    `CHK("flag_w0", 1'b1, rd[0])
    bus(OFS_FLAGS, 1'b1, 32'h1);
    tick(2);
    `CHK("irq_w1c", 1'b0, compare_irq)
    bus(OFS_CTRL, 1'b1, 32'h0b);
    bus(OFS_COMPARE, 1'b1, 32'h28);
    bus(OFS_CTRL, 1'b1, 32'h1b);
    wait_pin(1'b0);
    wait_pin(1'b1);
    t1 = t0;
    fork
      bus(OFS_COMPARE, 1'b1, 32'h2);
      wait_pin(1'b0);
    join
    `CHK("high_old", 41, t0 - t1)
    wait_pin(1'b1);
    t1 = t0;
    wait_pin(1'b0);
    `CHK("high_new", 3, t0 - t1)
    bus(OFS_CTRL, 1'b1, 32'h0b);
    bus(OFS_COMPARE, 1'b1, 32'h55);
    bus(OFS_COMPARE, 1'b0, 32'h0);
    `CHK("cmp_buffer", 32'h55, rd)
    m_wave = pin_level;
    bus(OFS_CTRL, 1'b1, 32'h08);
    tick(2);
    `CHK("wave_kept", m_wave, pin_level)
    bus(OFS_CTRL, 1'b1, 32'h00);
    bus(OFS_COMPARE, 1'b1, 32'h10);
    bus(OFS_COUNT, 1'b1, 32'h10); // equal on purpose to see the drop
    bus(OFS_COUNT, 1'b0, 32'h0);
    `CHK("count_rd", 32'h10, rd)
    bus(OFS_FLAGS, 1'b1, 32'h3);
    bus(OFS_CTRL, 1'b1, 32'h10);
    t0 = cyc;
    wait_cmp;
    `CHK("first_match_late", 1'b1, t1 - t0 > 250)
    bus(OFS_FLAGS, 1'b0, 32'h0);
    `CHK("ovf_flag", 1'b1, rd[1])
    `CHK("ovf_irq_masked", 1'b0, overflow_irq)
    period(256, 1, 1'b0);
    bus(OFS_IRQEN, 1'b1, 32'h3);
    tick(2);
    `CHK("ovf_irq_on", 1'b1, overflow_irq)
    @(posedge clk_sys);
    overflow_irq_ack <= 1'b1;
    @(posedge clk_sys);
    overflow_irq_ack <= 1'b0;
    tick(2);
    `CHK("ovf_irq_ack", 1'b0, overflow_irq)
    // phase correct: low from up match to down match
    bus(OFS_CTRL, 1'b1, 32'h09);
    bus(OFS_COMPARE, 1'b1, 32'hf0);
    bus(OFS_CTRL, 1'b1, 32'h19);
    wait_pin(1'b1);
    wait_pin(1'b0);
    t1 = t0;
    wait_pin(1'b1);
    `CHK("pc_low", 2 * (int'(CNT_MAX) - 32'hf0), t0 - t1)
    close_out;
  end
endmodule
`default_nettype wire
